// ==== hdl/lcc_pkg.sv ====
/*
 logic cluster shared package: register map, control field positions,
 reset values, operating modes and the carrier types between the cluster
 and its cells. assumes a 32-bit Avalon-MM register port with byte addresses.
*/
package lcc_pkg;
	localparam int CELLS = 10;
	localparam int COLUMN_CLUSTERS = 4;

	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_OPA = 8'h04;
	localparam logic [7:0] A_OPB = 8'h08;
	localparam logic [7:0] A_OPC = 8'h0C;
	localparam logic [7:0] A_RES = 8'h10;
	localparam logic [7:0] A_COMB = 8'h14;
	localparam logic [7:0] A_THIRD = 8'h18;
	localparam logic [7:0] A_CLRSEL = 8'h1C;

	localparam int F_MODE = 0;
	localparam int F_HALF = 3;
	localparam int F_FRESH = 4;
	localparam int F_DCLR = 5;
	localparam int F_CE = 6;
	localparam int F_CLR0 = 7;
	localparam int F_CLR1 = 8;
	localparam int F_PRE = 9;
	localparam int F_SHIFT = 10;
	localparam int F_SIN = 11;

	localparam logic [31:0] CTRL_RST = 32'h0000_0041;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic [2:0] {
		M_NORMAL = 3'b001,
		M_SHARED = 3'b010,
		M_LUTREG = 3'b100
	} lcc_mode_t;

	typedef struct packed {
		logic carry;
		logic share;
	} lcc_chain_t;

	typedef struct packed {
		lcc_mode_t mode;
		logic used;
		logic ce;
		logic clr;
		logic dclr;
		logic shift;
		logic pre;
	} lcc_ctl_t;
endpackage

// ==== hdl/lcc_sync.sv ====
/*
 two-stage synchroniser for one level arriving from a device pin.
 assumes the pin is inactive high; the output idles high under reset.
*/
`timescale 1ns/10ps
`default_nettype none
module lcc_sync (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_async,
	output var logic o_sync
);
	logic meta_r;
	logic sync_r;

	// first stage feeds only the second stage
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			meta_r <= 1'h1;
			sync_r <= 1'h1;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;
endmodule
`default_nettype wire

// ==== hdl/lcc_cell.sv ====
/*
 one logic cell: four lookup tables giving partial sum and carry of three
 operand bits, lower and upper adder on the shared chain, two dedicated
 registers on the cascade path and a third register built from two latch luts.
 assumes the cluster supplies one gated enable and already-resolved clears.
*/
`timescale 1ns/10ps
`default_nettype none
module lcc_cell (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire lcc_pkg::lcc_ctl_t i_ctl,
	input wire logic [1:0] i_x,
	input wire logic [1:0] i_y,
	input wire logic [1:0] i_z,
	input wire logic i_d3,
	input wire lcc_pkg::lcc_chain_t i_chain,
	output var lcc_pkg::lcc_chain_t o_chain,
	input wire logic i_casc,
	output var logic o_casc,
	output var logic [1:0] o_q,
	output var logic [1:0] o_comb,
	output var logic o_third
);
	import lcc_pkg::*;

	logic [1:0] s_w;
	logic [1:0] c_w;
	logic [1:0] q_r;
	logic [1:0] d_w;
	logic used_w;
	logic la_w;
	logic lb_w;
	logic lc_w;
	logic lk_w;
	logic ua_w;
	logic ub_w;
	logic r0_w;
	logic r1_w;
	logic uk_w;
	logic pre_w;
	logic master_latch_lut;
	logic slave_latch_lut_r;

	assign s_w = i_x ^ i_y ^ i_z;
	assign c_w = (i_x & i_y) | (i_x & i_z) | (i_y & i_z);
	assign used_w = i_ctl.used && (i_ctl.mode == M_SHARED);

	// idle adders see zeros so they never toggle
	assign la_w = used_w & s_w[0];
	assign lb_w = used_w & i_chain.share;
	assign lc_w = used_w & i_chain.carry;
	assign ua_w = used_w & s_w[1];
	assign ub_w = used_w & c_w[0];
	assign r0_w = la_w ^ lb_w ^ lc_w;
	assign lk_w = (la_w & lb_w) | (la_w & lc_w) | (lb_w & lc_w);
	assign r1_w = ua_w ^ ub_w ^ lk_w;
	assign uk_w = (ua_w & ub_w) | (ua_w & lk_w) | (ub_w & lk_w);
	assign o_chain = '{carry: uk_w, share: used_w & c_w[1]};

	// preset: store inverted data, clear then reads back as one
	assign pre_w = i_ctl.pre;
	assign d_w = i_ctl.shift ? {o_q[0], i_casc} : {r1_w, r0_w};

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			q_r <= 2'h0;
		end else if (i_ctl.dclr) begin
			q_r <= 2'h0;
		end else if (i_ctl.clr) begin
			q_r <= 2'h0;
		end else if (i_ctl.ce) begin
			q_r <= d_w ^ {2{pre_w}};
		end
	end

	assign o_q = q_r ^ {2{pre_w}};
	assign o_casc = o_q[1];
	assign o_comb = s_w;

	// feedback pair: master follows data while enabled in lut-register mode, else holds the slave
	assign master_latch_lut = (i_ctl.ce && i_ctl.mode == M_LUTREG) ?
		(i_d3 ^ pre_w) : slave_latch_lut_r;

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			slave_latch_lut_r <= 1'h0;
		end else if (i_ctl.dclr) begin
			slave_latch_lut_r <= 1'h0;
		end else if (i_ctl.clr) begin
			slave_latch_lut_r <= 1'h0;
		end else begin
			slave_latch_lut_r <= master_latch_lut;
		end
	end

	assign o_third = slave_latch_lut_r ^ pre_w;

	property p_third;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_ctl.mode == M_LUTREG && i_ctl.ce && !i_ctl.clr && !i_ctl.dclr && !pre_w)
		|=> slave_latch_lut_r == $past(i_d3);
	endproperty
	a_third: assert property (p_third) else $error("third register missed data");

	property p_clr3;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		i_ctl.clr |=> (slave_latch_lut_r == 1'h0 && q_r == 2'h0);
	endproperty
	a_clr3: assert property (p_clr3) else $error("third register ignored clear");
endmodule
`default_nettype wire

// ==== hdl/lcc_cluster.sv ====
/*
 logic cluster: ten cells on a shared arithmetic chain and a register
 cascade, cluster-wide clears, device-wide clear and the gated cluster clock,
 all steered from an Avalon-MM register slave.
 assumes neighbouring clusters in the column run on the same clock and
 connect o_chain to the next cluster's i_chain.
*/
// Behaviour
// - luts form partial sum and carry, adders give the three-operand result
// - shared chain enters a cluster only at cell one or cell six
// - twenty chain bits per cluster; longer chains continue down the column
// - alternate columns bypass top half, others bottom half of the chain
// - master and slave latch luts with feedback form a third register
// - third register shares clock, enable and clear with top register
// - cascade path feeds each register output to the next cell register
// - luts stay usable for unrelated logic while registers shift
// - registers have cluster clear; at most two clear sources per cluster
// - preset comes from inverted data and output plus the clear
// - enabled device-wide clear clears everything and overrides all controls
// - unused adders have all inputs held low
// - cluster clock always paired with its own clock enable
// - registers sharing clock and enable use one gated clock
// - shared mode uses four four-input luts for sum or carry
// - carry runs lower adder, upper adder, then next cell lower adder
// - top-half chains continue top half, bottom-half chains bottom half
`timescale 1ns/10ps
`default_nettype none
module lcc_cluster #(
	parameter int N_CELLS = lcc_pkg::CELLS,
	parameter bit TOP_BYPASS = 1'b1,
	parameter int ROW = 0,
	parameter int COL_HEIGHT = lcc_pkg::COLUMN_CLUSTERS
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output var logic [31:0] o_avs_readdata,
	output var logic o_avs_waitrequest,
	input wire lcc_pkg::lcc_chain_t i_chain,
	output var lcc_pkg::lcc_chain_t o_chain,
	input wire logic i_device_wide_clear_n
);
	import lcc_pkg::*;

	localparam int DW = 2 * N_CELLS;
	localparam int HALF = N_CELLS / 2;
	localparam bit LAST = (ROW == COL_HEIGHT - 1);

	if (N_CELLS < 2 || N_CELLS > 15 || (N_CELLS % 2) != 0) begin : g_bad_cells
		$error("cell count must be even and between 2 and 14");
	end
	if (ROW < 0 || ROW >= COL_HEIGHT) begin : g_bad_row
		$error("row must lie inside the column");
	end

	logic [31:0] ctrl_r;
	logic [31:0] clrsel_r;
	logic [31:0] rdata_r;
	logic [DW-1:0] opa_r;
	logic [DW-1:0] opb_r;
	logic [DW-1:0] opc_r;
	logic [DW-1:0] res_w;
	logic [DW-1:0] comb_w;
	logic [DW-1:0] sum3_w;
	logic [N_CELLS-1:0] third_w;
	logic [N_CELLS-1:0] in_chain_w;
	logic [N_CELLS:0] casc_w;
	lcc_chain_t ch_in_w [N_CELLS];
	lcc_chain_t ch_out_w [N_CELLS];
	lcc_chain_t ent_w;
	lcc_mode_t mode_w;
	logic ack_r;
	logic req_w;
	logic wr_w;
	logic dclr_n_s;
	logic dclr_w;
	logic block_clock_enable_one;
	logic shared_w;
	logic top_byp_w;
	logic bot_byp_w;

	function automatic logic [31:0] merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0] be
	);
		logic [31:0] m;
		m = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				m[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return m;
	endfunction

	// bus slave: one wait cycle on every access, writes land on the release edge
	assign req_w = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req_w & ~ack_r;
	assign wr_w = i_avs_write & ack_r;

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			ack_r <= 1'h0;
		end else begin
			ack_r <= req_w & ~ack_r;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			rdata_r <= WORD_ZERO;
		end else if (i_avs_read && !ack_r) begin
			case (i_avs_address)
				A_CTRL: rdata_r <= ctrl_r;
				A_OPA: rdata_r <= 32'(opa_r);
				A_OPB: rdata_r <= 32'(opb_r);
				A_OPC: rdata_r <= 32'(opc_r);
				A_RES: rdata_r <= 32'(res_w);
				A_COMB: rdata_r <= 32'(comb_w);
				A_THIRD: rdata_r <= 32'(third_w);
				A_CLRSEL: rdata_r <= clrsel_r;
				default: rdata_r <= WORD_ZERO;
			endcase
		end
	end

	assign o_avs_readdata = rdata_r;

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			ctrl_r <= CTRL_RST;
		end else if (wr_w && i_avs_address == A_CTRL) begin
			ctrl_r <= merge(ctrl_r, i_avs_writedata, i_avs_byteenable);
		end
	end

	// only one select bit per cell, so two clear sources at most
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			clrsel_r <= WORD_ZERO;
		end else if (wr_w && i_avs_address == A_CLRSEL) begin
			clrsel_r <= 32'(N_CELLS'(merge(clrsel_r, i_avs_writedata, i_avs_byteenable)));
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			opa_r <= DW'(WORD_ZERO);
			opb_r <= DW'(WORD_ZERO);
			opc_r <= DW'(WORD_ZERO);
		end else if (wr_w) begin
			if (i_avs_address == A_OPA) begin
				opa_r <= DW'(merge(32'(opa_r), i_avs_writedata, i_avs_byteenable));
			end
			if (i_avs_address == A_OPB) begin
				opb_r <= DW'(merge(32'(opb_r), i_avs_writedata, i_avs_byteenable));
			end
			if (i_avs_address == A_OPC) begin
				opc_r <= DW'(merge(32'(opc_r), i_avs_writedata, i_avs_byteenable));
			end
		end
	end

	// unknown mode codes fall back to plain logic
	always_comb begin
		case (ctrl_r[F_MODE +: 3])
			M_SHARED: mode_w = M_SHARED;
			M_LUTREG: mode_w = M_LUTREG;
			default: mode_w = M_NORMAL;
		endcase
	end

	lcc_sync u_dclr (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_async(i_device_wide_clear_n),
		.o_sync(dclr_n_s)
	);

	assign dclr_w = ctrl_r[F_DCLR] & ~dclr_n_s;
	// gated cluster clock modelled as one shared enable on the single clock
	assign block_clock_enable_one = ctrl_r[F_CE];

	assign shared_w = (mode_w == M_SHARED);
	assign top_byp_w = ctrl_r[F_HALF] & TOP_BYPASS;
	assign bot_byp_w = ctrl_r[F_HALF] & ~TOP_BYPASS;
	assign ent_w = ctrl_r[F_FRESH] ? '0 : i_chain;
	assign casc_w[0] = ctrl_r[F_SIN];

	for (genvar i = 0; i < N_CELLS; i++) begin : g_cell
		lcc_ctl_t ctl_w;

		if (i == 0) begin : g_top_entry
			assign ch_in_w[i] = ent_w;
		end else if (i == HALF) begin : g_mid_entry
			assign ch_in_w[i] = top_byp_w ? ent_w : ch_out_w[i-1];
		end else begin : g_link
			assign ch_in_w[i] = ch_out_w[i-1];
		end

		assign in_chain_w[i] = shared_w & ~(top_byp_w & (i < HALF)) &
			~(bot_byp_w & (i >= HALF));

		assign ctl_w = '{
			mode: mode_w,
			used: in_chain_w[i],
			ce: block_clock_enable_one,
			clr: clrsel_r[i] ? ctrl_r[F_CLR1] : ctrl_r[F_CLR0],
			dclr: dclr_w,
			shift: ctrl_r[F_SHIFT],
			pre: ctrl_r[F_PRE]
		};

		lcc_cell u_cell (
			.i_ref_clk(i_ref_clk),
			.i_resetn(i_resetn),
			.i_ctl(ctl_w),
			.i_x(opa_r[2*i +: 2]),
			.i_y(opb_r[2*i +: 2]),
			.i_z(opc_r[2*i +: 2]),
			.i_d3(opc_r[2*i]),
			.i_chain(ch_in_w[i]),
			.o_chain(ch_out_w[i]),
			.i_casc(casc_w[i]),
			.o_casc(casc_w[i+1]),
			.o_q(res_w[2*i +: 2]),
			.o_comb(comb_w[2*i +: 2]),
			.o_third(third_w[i])
		);

		// clears ignore the enable, so a gated cell still drops its data
		property p_clr;
			@(posedge i_ref_clk) disable iff (!i_resetn)
			(ctl_w.clr && !wr_w) |=> (res_w[2*i +: 2] == {2{ctrl_r[F_PRE]}});
		endproperty
		a_clr: assert property (p_clr) else $error("selected clear missed a cell");
	end

	// the last cluster of the column ends every chain
	assign o_chain = LAST ? '0 :
		(bot_byp_w ? ch_out_w[HALF-1] : ch_out_w[N_CELLS-1]);

	assign sum3_w = opa_r + opb_r + opc_r;

	property p_sum;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		(shared_w && !ctrl_r[F_HALF] && ctrl_r[F_FRESH] && block_clock_enable_one &&
			!ctrl_r[F_CLR0] && !ctrl_r[F_CLR1] && !dclr_w && !wr_w &&
			!ctrl_r[F_SHIFT] && !ctrl_r[F_PRE])
		|=> res_w == $past(sum3_w);
	endproperty
	a_sum: assert property (p_sum) else $error("registered sum differs from a+b+c");

	property p_dclr;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		(dclr_w && !wr_w) |=> (res_w == {DW{ctrl_r[F_PRE]}} &&
			third_w == {N_CELLS{ctrl_r[F_PRE]}});
	endproperty
	a_dclr: assert property (p_dclr) else $error("device clear did not clear");

	property p_gate;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		(!block_clock_enable_one && !ctrl_r[F_CLR0] && !ctrl_r[F_CLR1] &&
			!dclr_w && !wr_w) |=> ($stable(res_w) && $stable(third_w));
	endproperty
	a_gate: assert property (p_gate) else $error("register moved with clock gated");

	property p_shift;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		(ctrl_r[F_SHIFT] && block_clock_enable_one && !ctrl_r[F_CLR0] &&
			!ctrl_r[F_CLR1] && !dclr_w && !wr_w && !ctrl_r[F_PRE])
		|=> (res_w[0] == $past(ctrl_r[F_SIN]) && res_w[2] == $past(res_w[1]));
	endproperty
	a_shift: assert property (p_shift) else $error("cascade did not shift");

	property p_byp;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		top_byp_w |-> (ch_in_w[HALF] == ent_w && !in_chain_w[0]);
	endproperty
	a_byp: assert property (p_byp) else $error("bypass did not forward chain");

	property p_half;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		(bot_byp_w && !LAST) |-> (o_chain == ch_out_w[HALF-1] && !in_chain_w[HALF]);
	endproperty
	a_half: assert property (p_half) else $error("half chain left wrong cell");

	property p_full;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		(top_byp_w && !LAST) |-> (o_chain == ch_out_w[N_CELLS-1] && !in_chain_w[HALF-1]);
	endproperty
	a_full: assert property (p_full) else $error("top bypass left wrong cell");

	property p_entry;
		@(posedge i_ref_clk) disable iff (!i_resetn)
		!ctrl_r[F_HALF] |-> (ch_in_w[HALF] == ch_out_w[HALF-1]);
	endproperty
	a_entry: assert property (p_entry) else $error("chain entered mid cluster");
endmodule
`default_nettype wire

// ==== testbench/lcc_nbr.sv ====
/*
 neighbour cluster above: drives the shared chain into the cluster.
 assumes it runs on the cluster clock, so no synchroniser is needed.
*/
`timescale 1ns/10ps
`default_nettype none
module lcc_nbr (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_use,
	input wire lcc_pkg::lcc_chain_t i_val,
	output var lcc_pkg::lcc_chain_t o_chain
);
	import lcc_pkg::*;
	// idle adders hold the chain low, so nothing toggles downstream
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn || !i_use) begin
			o_chain <= '0;
		end else begin
			o_chain <= i_val;
		end
	end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
/*
 self-checking bench for the logic cluster: bus tasks, one task a scenario.
 assumes a slave that inserts at most 50 wait cycles; the pin is async.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import lcc_pkg::*;
	logic clk, rst_n, rd_s, wr_s, pin_n, nbr_use;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, rdat_b;
	logic waitreq;
	lcc_chain_t up_chain, nbr_val, dn_chain, dn_b;
	int n_errors, n_checks;

	lcc_nbr lcc_nbr_i (.i_ref_clk(clk), .i_resetn(rst_n), .i_use(nbr_use),
		.i_val(nbr_val), .o_chain(up_chain));
	lcc_cluster lcc_cluster_i (.i_ref_clk(clk), .i_resetn(rst_n), .i_avs_address(adr),
		.i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdat),
		.i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(waitreq),
		.i_chain(up_chain), .o_chain(dn_chain), .i_device_wide_clear_n(pin_n));
	// second copy bypasses the bottom half, fed by the same bus traffic
	lcc_cluster #(.TOP_BYPASS(1'b0)) lcc_cluster_bot_i (.i_ref_clk(clk), .i_resetn(rst_n),
		.i_avs_address(adr), .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdat),
		.i_avs_byteenable(4'hF), .o_avs_readdata(rdat_b), .o_avs_waitrequest(),
		.i_chain(up_chain), .o_chain(dn_b), .i_device_wide_clear_n(pin_n));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// sampled at the rising edge, before that edge's updates land
	task automatic wait_ack();
		int k;
		k = 0;
		@(posedge clk);
		while (waitreq !== 1'b0 && k < 50) begin
			@(posedge clk);
			k++;
		end
		if (waitreq !== 1'b0) begin
			n_errors++;
			$display("CHECK FAILED waitrequest expected 0 seen %b", waitreq);
			stop_test();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wdat <= d;
		wr_s <= 1'b1;
		wait_ack();
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		adr <= a;
		rd_s <= 1'b1;
		wait_ack();
		d = rdat;
		rd_s <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		rd(a, r);
		chk(nm, exp, r);
	endtask

	task automatic ops(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
		wr(A_OPA, a);
		wr(A_OPB, b);
		wr(A_OPC, c);
	endtask

	task automatic t_reset();
		rchk("ctrl", A_CTRL, CTRL_RST);
		rchk("opa", A_OPA, WORD_ZERO);
		rchk("clrsel", A_CLRSEL, WORD_ZERO);
		rchk("third", A_THIRD, WORD_ZERO);
		wr(A_RES, 32'h0000_0123);
		rchk("res_ro", A_RES, WORD_ZERO);
		rchk("unmapped", 8'h20, WORD_ZERO);
		$display("test reset done");
	endtask

	task automatic t_sum();
		nbr_val <= 2'b10;
		nbr_use <= 1'b1;
		ops(32'h000F_FFFF, 32'h000F_FFFF, 32'h0000_0001);
		wr(A_CTRL, 32'h0000_0052);
		rchk("res_wide", A_RES, 32'h000F_FFFF);
		chk("chain_out", 32'h0000_0001, 32'(dn_chain));
		ops(32'h0000_000E, 32'h0000_0004, 32'h0000_000D);
		rchk("res_sum", A_RES, 32'h0000_001F);
		rchk("comb", A_COMB, 32'h0000_0007);
		wr(A_CTRL, 32'h0000_0042);
		rchk("res_chain_in", A_RES, 32'h0000_0020);
		wr(A_CTRL, 32'h0000_0052);
		rchk("res_fresh", A_RES, 32'h0000_001F);
		$display("test shared sum done");
	endtask

	task automatic t_half();
		nbr_use <= 1'b0;
		ops(32'h0000_0FFF, 32'h0000_0401, 32'h0000_0800);
		rchk("res_full", A_RES, 32'h0000_1C00);
		wr(A_CTRL, 32'h0000_005A);
		rchk("res_half_upper", A_RES, 32'h0000_1800);
		chk("chain_top_half", WORD_ZERO, 32'(dn_chain));
		chk("res_half_lower", WORD_ZERO, rdat_b);
		chk("chain_bottom_half", 32'h0000_0002, 32'(dn_b));
		$display("test half chain done");
	endtask

	task automatic t_shift();
		wr(A_CTRL, 32'h0000_0C81);
		wr(A_CTRL, 32'h0000_0C01);
		// three enabled edges span landing of the first write to the second
		wr(A_CTRL, 32'h0000_0C41);
		wr(A_CTRL, 32'h0000_0C01);
		rchk("res_shift", A_RES, 32'h0000_0007);
		rchk("comb_shift", A_COMB, 32'h0000_03FE);
		rchk("res_gated", A_RES, 32'h0000_0007);
		$display("test shift done");
	endtask

	task automatic t_clear();
		wr(A_CLRSEL, 32'h0000_03FF);
		wr(A_CTRL, 32'h0000_0C81);
		rchk("res_clr_unsel", A_RES, 32'h0000_0007);
		wr(A_CTRL, 32'h0000_0D01);
		rchk("res_clr_sel", A_RES, WORD_ZERO);
		wr(A_CTRL, 32'h0000_0301);
		rchk("res_preset", A_RES, 32'h000F_FFFF);
		$display("test clear done");
	endtask

	task automatic t_third();
		wr(A_CLRSEL, WORD_ZERO);
		wr(A_OPC, 32'h0000_0005);
		wr(A_CTRL, 32'h0000_0044);
		rchk("third_load", A_THIRD, 32'h0000_0003);
		wr(A_CTRL, 32'h0000_0004);
		wr(A_OPC, WORD_ZERO);
		rchk("third_hold", A_THIRD, 32'h0000_0003);
		wr(A_CTRL, 32'h0000_0084);
		rchk("third_clr", A_THIRD, WORD_ZERO);
		$display("test third register done");
	endtask

	task automatic t_dclr();
		ops(32'h0000_000E, 32'h0000_0004, 32'h0000_000D);
		wr(A_CTRL, 32'h0000_0052);
		@(posedge clk);
		pin_n <= 1'b0;
		repeat (5) @(posedge clk);
		rchk("res_dclr_off", A_RES, 32'h0000_001F);
		wr(A_CTRL, 32'h0000_0072);
		repeat (5) @(posedge clk);
		rchk("res_dclr_on", A_RES, WORD_ZERO);
		@(posedge clk);
		pin_n <= 1'b1;
		repeat (5) @(posedge clk);
		rchk("res_dclr_end", A_RES, 32'h0000_001F);
		$display("test device clear done");
	endtask

	initial begin
		n_errors = 0;
		n_checks = 0;
		rst_n = 1'b0;
		rd_s = 1'b0;
		wr_s = 1'b0;
		adr = 8'h00;
		wdat = WORD_ZERO;
		pin_n = 1'b1;
		nbr_use = 1'b0;
		nbr_val = 2'b00;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_sum();
		t_half();
		t_shift();
		t_clear();
		t_third();
		t_dclr();
		stop_test();
	end
endmodule
`default_nettype wire
